//--- logic/isp_pkg.sv
package isp_pkg;

  // ****************************************************************
  // Entry numbers of the parameter set
  // ****************************************************************
  localparam logic [7:0] IDX_HIGHEST = 8'h00;
  localparam logic [7:0] IDX_MODE = 8'h01;
  localparam logic [7:0] IDX_CYCLE = 8'h02;
  localparam logic [7:0] IDX_SHIFT = 8'h03;
  localparam logic [7:0] IDX_SUPPORTED = 8'h04;
  localparam logic [7:0] IDX_MIN_CYCLE = 8'h05;
  localparam logic [7:0] IDX_CALC_COPY = 8'h06;
  localparam logic [7:0] IDX_COMMAND = 8'h08;
  localparam logic [7:0] IDX_DELAY = 8'h09;
  localparam logic [7:0] IDX_MISSED = 8'h0B;
  localparam logic [7:0] IDX_OVERRUN = 8'h0C;
  localparam logic [7:0] IDX_SHORT = 8'h0D;
  localparam logic [7:0] IDX_FAULT = 8'h20;

  // ****************************************************************
  // Reset values and fields
  // ****************************************************************
  localparam logic [7:0] HIGHEST_VALUE = 8'h07;
  localparam logic [15:0] SUPPORTED_RESET = 16'h8007;
  localparam int SUP_SHIFT_LSB = 4;
  localparam int SUP_DYNAMIC_BIT = 14;
  localparam logic [1:0] SUP_SHIFT_LOCAL = 2'h1;
  localparam logic [1:0] SUP_SHIFT_SECOND = 2'h2;
  localparam logic [15:0] CMD_STOP = 16'h0000;
  localparam logic [15:0] CMD_START = 16'h0001;

  // ****************************************************************
  // Synchronization modes
  // ****************************************************************
  localparam logic [15:0] MODE_FREE_RUN = 16'h0000;
  localparam logic [15:0] MODE_INPUT_EVENT = 16'h0001;
  localparam logic [15:0] MODE_FIRST_PULSE = 16'h0002;
  localparam logic [15:0] MODE_SECOND_PULSE = 16'h0003;
  localparam logic [15:0] MODE_OUTPUT_EVENT = 16'h0022;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam logic [31:0] CLK_STEP_NS = 32'(CLK_PERIOD_NS);

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic req;
    logic write;
    logic [7:0] subindex;
    logic [31:0] wdata;
  } isp_access_t;

  typedef struct packed {
    logic ack;
    logic error;
    logic [31:0] rdata;
  } isp_answer_t;

endpackage : isp_pkg

//--- logic/isp_unit.sv
// Function
// - Mode field resets zero; 0 free run, 1 input event, 34 output event.
// - Mode 2 locks sampling to first pulse, mode 3 to second pulse.
// - Cycle period is local timer period in free run, else reference period.
// - In pulse mode, shift gives delay from first pulse to sampling.
// - Supported map resets 0x8007: free run, buffer event, pulse mode.
// - Map bits 4-5 read 01 with outputs, 10 without outputs.
// - Map bit 14 flags dynamic times measured on command write.
// - Minimum period entry is read-only and gives the shortest cycle.
// - Sample-to-ready entry gives time from sampling to inputs ready.
// - Command 1 starts measurement, 0 stops it; resets to zero.
// - While measuring, shift (except in mode 2), sample-to-ready and delay keep maxima.
// - Starting a measurement first clears previous maxima.
// - Delay entry gives time from second pulse to sampling.
// - Missed buffer events in running pulse mode are counted.
// - Samplings while the previous cycle is still busy in the running state are counted.
// - In pulse mode, too short spacing between first and second pulse is counted.
// - In pulse mode, fault flag reports outputs driven too late in the last cycle.
// - Header entry reads 0x07 and is read-only.
`timescale 1ns/100ps
`default_nettype none

module isp_unit #(
  parameter logic [31:0] MIN_CYCLE_NS = 32'h00000000,
  parameter logic [31:0] MIN_SPACING_NS = 32'h00000000,
  parameter logic DYNAMIC_TIMES = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire isp_pkg::isp_access_t acc,
  output isp_pkg::isp_answer_t ans,
  input wire logic first_sync_pulse,
  input wire logic second_sync_pulse,
  input wire logic input_buffer_event,
  input wire logic output_buffer_event,
  input wire logic running_state,
  input wire logic outputs_present,
  input wire logic inputs_ready,
  input wire logic outputs_late,
  output logic sample_trigger
);

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  localparam int NPIN = 8;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;
  logic [NPIN-1:0] pin_prev;
  logic [NPIN-1:0] pin_rise;

  assign pin_raw = {outputs_late, inputs_ready, outputs_present, running_state,
                    output_buffer_event, input_buffer_event, second_sync_pulse, first_sync_pulse};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
          pin_prev[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
          pin_prev[gi] <= pin_sync[gi];
        end
      end
      assign pin_rise[gi] = pin_sync[gi] & ~pin_prev[gi];
    end
  endgenerate

  logic p0;
  logic p1;
  logic ev_in;
  logic ev_out;
  logic running;
  logic has_outputs;
  logic ready_ev;
  logic late_ev;
  assign p0 = pin_rise[0];
  assign p1 = pin_rise[1];
  assign ev_in = pin_rise[2];
  assign ev_out = pin_rise[3];
  assign running = pin_sync[4];
  assign has_outputs = pin_sync[5];
  assign ready_ev = pin_rise[6];
  assign late_ev = pin_rise[7];

  // ****************************************************************
  // Configuration entries
  // ****************************************************************
  logic [15:0] sync_mode_select;
  logic [31:0] cycle_period_ns;
  logic [31:0] pulse_to_sample_shift_ns;
  logic [15:0] supported_modes_map;
  logic [31:0] sample_to_ready_ns;
  logic [15:0] measure_command;
  logic [31:0] second_pulse_delay_ns;
  logic [15:0] missed_event_count;
  logic [15:0] overrun_count;
  logic [15:0] short_spacing_count;
  logic sync_fault_flag;

  logic wr;
  logic dc_mode;
  logic measuring;
  logic start_cmd;
  assign wr = acc.req & acc.write;
  assign dc_mode = (sync_mode_select == isp_pkg::MODE_FIRST_PULSE) ||
                   (sync_mode_select == isp_pkg::MODE_SECOND_PULSE);
  assign measuring = (measure_command == isp_pkg::CMD_START);
  assign start_cmd = wr && (acc.subindex == isp_pkg::IDX_COMMAND) && (acc.wdata[15:0] == isp_pkg::CMD_START);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_mode_select <= isp_pkg::MODE_FREE_RUN;
      cycle_period_ns <= 32'h00000000;
      measure_command <= isp_pkg::CMD_STOP;
    end else if (wr) begin
      if (acc.subindex == isp_pkg::IDX_MODE) sync_mode_select <= acc.wdata[15:0];
      if (acc.subindex == isp_pkg::IDX_CYCLE) cycle_period_ns <= acc.wdata;
      if (acc.subindex == isp_pkg::IDX_COMMAND) measure_command <= acc.wdata[15:0];
    end
  end

  // The shift bits depend on whether outputs exist, so they follow the strap after reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      supported_modes_map <= isp_pkg::SUPPORTED_RESET;
    end else begin
      supported_modes_map <= isp_pkg::SUPPORTED_RESET;
      supported_modes_map[isp_pkg::SUP_SHIFT_LSB +: 2] <=
        has_outputs ? isp_pkg::SUP_SHIFT_LOCAL : isp_pkg::SUP_SHIFT_SECOND;
      supported_modes_map[isp_pkg::SUP_DYNAMIC_BIT] <= DYNAMIC_TIMES;
    end
  end

  // ****************************************************************
  // Time keeping since the reference events
  // ****************************************************************
  logic [31:0] since_p0;
  logic [31:0] since_p1;
  logic [31:0] since_sample;
  logic [31:0] timer_ns;
  logic shift_armed;
  logic busy;
  logic fire;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since_p0 <= 32'h00000000;
      since_p1 <= 32'h00000000;
      since_sample <= 32'h00000000;
    end else begin
      since_p0 <= p0 ? 32'h00000000 : since_p0 + isp_pkg::CLK_STEP_NS;
      since_p1 <= p1 ? 32'h00000000 : since_p1 + isp_pkg::CLK_STEP_NS;
      since_sample <= fire ? 32'h00000000 : since_sample + isp_pkg::CLK_STEP_NS;
    end
  end

  // ****************************************************************
  // Sampling trigger
  // ****************************************************************
  always_comb begin
    case (sync_mode_select)
      isp_pkg::MODE_FREE_RUN: fire = (cycle_period_ns != 32'h00000000) &&
                                     (timer_ns + isp_pkg::CLK_STEP_NS >= cycle_period_ns);
      isp_pkg::MODE_INPUT_EVENT: fire = ev_in;
      isp_pkg::MODE_OUTPUT_EVENT: fire = ev_out;
      isp_pkg::MODE_FIRST_PULSE: fire = shift_armed && (since_p0 >= pulse_to_sample_shift_ns);
      isp_pkg::MODE_SECOND_PULSE: fire = p1;
      default: fire = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_ns <= 32'h00000000;
      shift_armed <= 1'b0;
      sample_trigger <= 1'b0;
    end else begin
      timer_ns <= (fire || sync_mode_select != isp_pkg::MODE_FREE_RUN) ? 32'h00000000 :
                  timer_ns + isp_pkg::CLK_STEP_NS;
      if (p0) shift_armed <= 1'b1;
      else if (fire) shift_armed <= 1'b0;
      sample_trigger <= fire;
    end
  end

  // A cycle is busy from its sampling until the inputs are ready for the master.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) busy <= 1'b0;
    else if (fire) busy <= 1'b1;
    else if (ready_ev) busy <= 1'b0;
  end

  // ****************************************************************
  // Measured maxima
  // ****************************************************************
  // In first-pulse mode the shift is a setting that drives sampling, so it is never overwritten.
  logic shift_measured;
  assign shift_measured = sync_mode_select != isp_pkg::MODE_FIRST_PULSE;

  // A pulse in the same cycle as sampling means a zero interval, not the time since the pulse before.
  logic [31:0] shift_now;
  logic [31:0] delay_now;
  assign shift_now = p0 ? 32'h00000000 : since_p0;
  assign delay_now = p1 ? 32'h00000000 : since_p1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_to_sample_shift_ns <= 32'h00000000;
      second_pulse_delay_ns <= 32'h00000000;
      sample_to_ready_ns <= 32'h00000000;
    end else if (start_cmd) begin
      if (shift_measured) pulse_to_sample_shift_ns <= 32'h00000000;
      second_pulse_delay_ns <= 32'h00000000;
      sample_to_ready_ns <= 32'h00000000;
    end else begin
      if (wr && acc.subindex == isp_pkg::IDX_SHIFT) pulse_to_sample_shift_ns <= acc.wdata;
      else if (measuring && fire && shift_measured && shift_now > pulse_to_sample_shift_ns)
        pulse_to_sample_shift_ns <= shift_now;
      if (measuring && fire && delay_now > second_pulse_delay_ns) second_pulse_delay_ns <= delay_now;
      if (measuring && ready_ev && busy && since_sample > sample_to_ready_ns)
        sample_to_ready_ns <= since_sample;
    end
  end

  // ****************************************************************
  // Diagnostics
  // ****************************************************************
  logic buf_seen;
  logic late_seen;
  logic missed_ev;
  logic overrun_ev;
  logic short_ev;
  assign missed_ev = dc_mode && running && p0 && !buf_seen;
  assign overrun_ev = running && fire && busy;
  assign short_ev = dc_mode && p1 && (shift_now < MIN_SPACING_NS);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_seen <= 1'b1;
      late_seen <= 1'b0;
    end else begin
      if (ev_in || ev_out) buf_seen <= 1'b1;
      else if (p0) buf_seen <= 1'b0;
      if (late_ev) late_seen <= 1'b1;
      else if (p0) late_seen <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      missed_event_count <= 16'h0000;
      overrun_count <= 16'h0000;
      short_spacing_count <= 16'h0000;
    end else begin
      if (missed_ev && missed_event_count != 16'hFFFF) missed_event_count <= missed_event_count + 16'h0001;
      if (overrun_ev && overrun_count != 16'hFFFF) overrun_count <= overrun_count + 16'h0001;
      if (short_ev && short_spacing_count != 16'hFFFF) short_spacing_count <= short_spacing_count + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sync_fault_flag <= 1'b0;
    else if (p0) sync_fault_flag <= dc_mode && (late_seen || late_ev);
  end

  // ****************************************************************
  // Entry access
  // ****************************************************************
  logic [31:0] rd_value;
  logic rd_known;
  logic ro_entry;

  always_comb begin
    rd_known = 1'b1;
    ro_entry = 1'b1;
    case (acc.subindex)
      isp_pkg::IDX_HIGHEST: rd_value = {24'h000000, isp_pkg::HIGHEST_VALUE};
      isp_pkg::IDX_MODE: begin
        rd_value = {16'h0000, sync_mode_select};
        ro_entry = 1'b0;
      end
      isp_pkg::IDX_CYCLE: begin
        rd_value = cycle_period_ns;
        ro_entry = 1'b0;
      end
      isp_pkg::IDX_SHIFT: begin
        rd_value = pulse_to_sample_shift_ns;
        ro_entry = 1'b0;
      end
      isp_pkg::IDX_SUPPORTED: rd_value = {16'h0000, supported_modes_map};
      isp_pkg::IDX_MIN_CYCLE: rd_value = MIN_CYCLE_NS;
      isp_pkg::IDX_CALC_COPY: rd_value = sample_to_ready_ns;
      isp_pkg::IDX_COMMAND: begin
        rd_value = {16'h0000, measure_command};
        ro_entry = 1'b0;
      end
      isp_pkg::IDX_DELAY: rd_value = second_pulse_delay_ns;
      isp_pkg::IDX_MISSED: rd_value = {16'h0000, missed_event_count};
      isp_pkg::IDX_OVERRUN: rd_value = {16'h0000, overrun_count};
      isp_pkg::IDX_SHORT: rd_value = {16'h0000, short_spacing_count};
      isp_pkg::IDX_FAULT: rd_value = {31'h00000000, sync_fault_flag};
      default: begin
        rd_value = 32'h00000000;
        rd_known = 1'b0;
      end
    endcase
  end

  // Writes to read-only entries are refused with an error and change nothing.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ans <= '0;
    end else begin
      ans.ack <= acc.req;
      ans.error <= acc.req && (!rd_known || (acc.write && ro_entry));
      ans.rdata <= (acc.req && !acc.write) ? rd_value : 32'h00000000;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_start_write;
    start_cmd;
  endsequence
  sequence s_cleared;
    second_pulse_delay_ns == 32'h00000000 && sample_to_ready_ns == 32'h00000000;
  endsequence

  a_mode_output_event: assert property ((sync_mode_select == isp_pkg::MODE_OUTPUT_EVENT && ev_out)
    |=> sample_trigger) else $error("output event did not trigger sampling");
  a_mode_second_pulse: assert property ((sync_mode_select == isp_pkg::MODE_SECOND_PULSE && p1)
    |=> sample_trigger) else $error("second pulse did not trigger sampling");
  a_shift_timing: assert property ((sync_mode_select == isp_pkg::MODE_FIRST_PULSE && fire)
    |-> since_p0 >= pulse_to_sample_shift_ns) else $error("sampled before shift elapsed");
  a_supported_map: assert property (##1 supported_modes_map[3:0] == 4'h7 && supported_modes_map[15])
    else $error("supported map base bits wrong");
  a_shift_bits: assert property ($rose(has_outputs) |=> supported_modes_map[5:4] == isp_pkg::SUP_SHIFT_LOCAL)
    else $error("shift bits do not follow outputs");
  a_start_clears: assert property (s_start_write |=> s_cleared)
    else $error("start did not clear maxima");
  a_delay_max: assert property ((measuring && fire && !start_cmd) |=> second_pulse_delay_ns >= $past(delay_now))
    else $error("delay maximum not kept");
  a_shift_max: assert property ((measuring && fire && shift_measured && !start_cmd &&
    !(wr && acc.subindex == isp_pkg::IDX_SHIFT))
    |=> pulse_to_sample_shift_ns >= $past(shift_now)) else $error("shift maximum not kept");
  a_missed_count: assert property ((missed_ev && missed_event_count != 16'hFFFF)
    |=> missed_event_count == $past(missed_event_count) + 16'h0001) else $error("missed event not counted");
  a_overrun_count: assert property ((overrun_ev && overrun_count != 16'hFFFF)
    |=> overrun_count == $past(overrun_count) + 16'h0001) else $error("overrun not counted");
  a_overrun_sat: assert property ((overrun_count == 16'hFFFF) |=> overrun_count == 16'hFFFF)
    else $error("overrun counter wrapped");
  a_short_count: assert property (short_ev && short_spacing_count != 16'hFFFF
    |=> $changed(short_spacing_count)) else $error("short spacing not counted");
  a_fault_flag: assert property ((p0 && dc_mode && late_seen) |=> sync_fault_flag)
    else $error("late outputs not flagged");
  a_header_ro: assert property ((acc.req && acc.write && acc.subindex == isp_pkg::IDX_HIGHEST)
    |=> ans.ack && ans.error) else $error("header write not refused");

endmodule : isp_unit

`default_nettype wire

//--- bench/isp_master_model.sv
`timescale 1ns/100ps
`default_nettype none

module isp_master_model (
  input wire logic clk,
  output logic first_sync_pulse,
  output logic second_sync_pulse,
  output logic input_buffer_event,
  output logic output_buffer_event,
  output logic outputs_late
);
  logic [4:0] pins;

  // Every event stays high for two cycles and low for one after, so each crosses the synchroniser.
  assign {outputs_late, output_buffer_event, input_buffer_event, second_sync_pulse, first_sync_pulse} = pins;

  initial begin
    pins = 5'h00;
  end

  task automatic strobe(input int which);
    @(negedge clk);
    pins[which] = 1'b1;
    repeat (2) @(negedge clk);
    pins[which] = 1'b0;
    @(negedge clk);
  endtask : strobe

  // Rising edges of the two pulses lie (4 + gap) cycles apart.
  task automatic pair(input int gap);
    strobe(0);
    repeat (gap) @(negedge clk);
    strobe(1);
  endtask : pair

endmodule : isp_master_model

`default_nettype wire

//--- bench/isp_unit_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module isp_unit_tb_top;
  logic clk;
  logic rst_n;
  isp_pkg::isp_access_t acc;
  isp_pkg::isp_answer_t ans;
  logic first_sync_pulse, second_sync_pulse, input_buffer_event, output_buffer_event, outputs_late;
  logic running_state;
  logic outputs_present;
  logic inputs_ready;
  logic sample_trigger;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  int trig_n = 0;
  int trig_at = 0;
  logic [31:0] rd, base;
  logic er;
  int t0, t1;
  logic [7:0] ro_subs [9] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h09, 8'h0B, 8'h0C, 8'h0D, 8'h20};
  logic [7:0] bad_subs [3] = '{8'h07, 8'h0A, 8'h21};
  logic [15:0] modes [4] = '{16'h0001, 16'h0022, 16'h0003, 16'h0005};
  int mode_pin [4] = '{2, 3, 1, 0};
  logic [31:0] mode_fires [4] = '{32'h1, 32'h1, 32'h1, 32'h0};

  always #50 clk = ~clk;

  isp_unit #(.MIN_CYCLE_NS(32'h000000C8), .MIN_SPACING_NS(32'h000001F4)) dut (
    .clk(clk), .rst_n(rst_n), .acc(acc), .ans(ans),
    .first_sync_pulse(first_sync_pulse), .second_sync_pulse(second_sync_pulse),
    .input_buffer_event(input_buffer_event), .output_buffer_event(output_buffer_event),
    .running_state(running_state), .outputs_present(outputs_present),
    .inputs_ready(inputs_ready), .outputs_late(outputs_late), .sample_trigger(sample_trigger)
  );

  isp_master_model model (
    .clk(clk), .first_sync_pulse(first_sync_pulse), .second_sync_pulse(second_sync_pulse),
    .input_buffer_event(input_buffer_event), .output_buffer_event(output_buffer_event),
    .outputs_late(outputs_late)
  );

  // ****************************************************************
  // Checking and reporting
  // ****************************************************************
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_range(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checks++;
    if (!(got >= lo && got <= hi)) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : check_range

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (sample_trigger === 1'b1) begin
      trig_n <= trig_n + 1;
      trig_at <= cyc;
    end
    if (cyc == 20000) begin
      mismatches++;
      final_report();
    end
  end

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic access(input logic wr, input logic [7:0] sub, input logic [31:0] wd);
    int n;
    n = 0;
    @(negedge clk);
    acc = '{req: 1'b1, write: wr, subindex: sub, wdata: wd};
    @(negedge clk);
    acc = '0;
    while (ans.ack !== 1'b1 && n < 3) begin
      @(negedge clk);
      n++;
    end
    rd = ans.rdata;
    er = ans.error;
    if (ans.ack !== 1'b1) begin
      check_word({31'h0, ans.ack}, 32'h1);
    end
  endtask : access

  task automatic rd_chk(input logic [7:0] sub, input logic [31:0] exp);
    access(1'b0, sub, 32'h0);
    check_word(rd, exp);
  endtask : rd_chk

  task automatic wr_reg(input logic [7:0] sub, input logic [31:0] wd, input logic exp_err);
    access(1'b1, sub, wd);
    check_word({31'h0, er}, {31'h0, exp_err});
  endtask : wr_reg

  task automatic wait_trig(output int at);
    int start, n;
    start = trig_n;
    n = 0;
    while (trig_n == start && n < 200) begin
      @(negedge clk);
      n++;
    end
    at = trig_at;
  endtask : wait_trig

  task automatic pulse_ready();
    @(negedge clk);
    inputs_ready = 1'b1;
    repeat (2) @(negedge clk);
    inputs_ready = 1'b0;
  endtask : pulse_ready

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    acc = '0;
    running_state = 1'b0;
    outputs_present = 1'b0;
    inputs_ready = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    rd_chk(isp_pkg::IDX_HIGHEST, 32'h07);
    rd_chk(isp_pkg::IDX_MODE, 32'h0);
    rd_chk(isp_pkg::IDX_CYCLE, 32'h0);
    rd_chk(isp_pkg::IDX_SHIFT, 32'h0);
    rd_chk(isp_pkg::IDX_SUPPORTED, 32'hC027);
    rd_chk(isp_pkg::IDX_MIN_CYCLE, 32'hC8);
    rd_chk(isp_pkg::IDX_CALC_COPY, 32'h0);
    rd_chk(isp_pkg::IDX_COMMAND, 32'h0);
    rd_chk(isp_pkg::IDX_DELAY, 32'h0);
    rd_chk(isp_pkg::IDX_MISSED, 32'h0);
    rd_chk(isp_pkg::IDX_OVERRUN, 32'h0);
    rd_chk(isp_pkg::IDX_SHORT, 32'h0);
    rd_chk(isp_pkg::IDX_FAULT, 32'h0);
    outputs_present = 1'b1;
    repeat (5) @(negedge clk);
    rd_chk(isp_pkg::IDX_SUPPORTED, 32'hC017);
    $display("Test done: reset values");
    foreach (ro_subs[i]) wr_reg(ro_subs[i], 32'hFFFFFFFF, 1'b1);
    foreach (bad_subs[i]) wr_reg(bad_subs[i], 32'h1, 1'b1);
    rd_chk(isp_pkg::IDX_HIGHEST, 32'h07);
    rd_chk(isp_pkg::IDX_MIN_CYCLE, 32'hC8);
    wr_reg(isp_pkg::IDX_MODE, 32'h22, 1'b0);
    rd_chk(isp_pkg::IDX_MODE, 32'h22);
    wr_reg(isp_pkg::IDX_CYCLE, 32'h12345678, 1'b0);
    rd_chk(isp_pkg::IDX_CYCLE, 32'h12345678);
    $display("Test done: access kinds");
    wr_reg(isp_pkg::IDX_MODE, 32'h0, 1'b0);
    wr_reg(isp_pkg::IDX_CYCLE, 32'd500, 1'b0);
    wait_trig(t0);
    wait_trig(t1);
    check_word(32'(t1 - t0), 32'd5);
    wr_reg(isp_pkg::IDX_CYCLE, 32'h0, 1'b0);
    repeat (8) @(negedge clk);
    t0 = trig_n;
    repeat (20) @(negedge clk);
    check_word(32'(trig_n - t0), 32'h0);
    $display("Test done: free run");
    foreach (modes[i]) begin
      wr_reg(isp_pkg::IDX_MODE, {16'h0, modes[i]}, 1'b0);
      t0 = trig_n;
      model.strobe(mode_pin[i]);
      repeat (8) @(negedge clk);
      check_word(32'(trig_n - t0), mode_fires[i]);
    end
    wr_reg(isp_pkg::IDX_SHIFT, 32'd1000, 1'b0);
    wr_reg(isp_pkg::IDX_MODE, 32'h2, 1'b0);
    t0 = cyc;
    model.strobe(0);
    wait_trig(t1);
    check_range(32'(t1 - t0), 32'd12, 32'd16);
    $display("Test done: mode select");
    pulse_ready();
    wr_reg(isp_pkg::IDX_MODE, 32'h3, 1'b0);
    wr_reg(isp_pkg::IDX_COMMAND, 32'h1, 1'b0);
    model.pair(4);
    repeat (2) @(negedge clk);
    pulse_ready();
    rd_chk(isp_pkg::IDX_COMMAND, 32'h1);
    access(1'b0, isp_pkg::IDX_SHIFT, 32'h0);
    check_range(rd, 32'd600, 32'd800);
    access(1'b0, isp_pkg::IDX_DELAY, 32'h0);
    check_range(rd, 32'd0, 32'd200);
    access(1'b0, isp_pkg::IDX_CALC_COPY, 32'h0);
    check_range(rd, 32'd100, 32'd600);
    wr_reg(isp_pkg::IDX_COMMAND, 32'h0, 1'b0);
    wr_reg(isp_pkg::IDX_COMMAND, 32'h1, 1'b0);
    model.pair(0);
    pulse_ready();
    access(1'b0, isp_pkg::IDX_SHIFT, 32'h0);
    check_range(rd, 32'd200, 32'd400);
    wr_reg(isp_pkg::IDX_COMMAND, 32'h0, 1'b0);
    model.pair(6);
    pulse_ready();
    access(1'b0, isp_pkg::IDX_SHIFT, 32'h0);
    check_range(rd, 32'd200, 32'd400);
    $display("Test done: measurement");
    running_state = 1'b1;
    wr_reg(isp_pkg::IDX_MODE, 32'h2, 1'b0);
    wr_reg(isp_pkg::IDX_SHIFT, 32'h0, 1'b0);
    access(1'b0, isp_pkg::IDX_SHORT, 32'h0);
    base = rd;
    model.strobe(4);
    model.pair(0);
    repeat (4) @(negedge clk);
    rd_chk(isp_pkg::IDX_SHORT, base + 32'h1);
    access(1'b0, isp_pkg::IDX_MISSED, 32'h0);
    base = rd;
    model.strobe(0);
    model.strobe(0);
    repeat (4) @(negedge clk);
    access(1'b0, isp_pkg::IDX_MISSED, 32'h0);
    check_range(rd, base + 32'h1, base + 32'h2);
    access(1'b0, isp_pkg::IDX_OVERRUN, 32'h0);
    check_range(rd, 32'h1, 32'h4);
    rd_chk(isp_pkg::IDX_FAULT, 32'h0);
    model.strobe(4);
    model.strobe(0);
    repeat (4) @(negedge clk);
    rd_chk(isp_pkg::IDX_FAULT, 32'h1);
    $display("Test done: diagnostics");
    final_report();
  end

endmodule : isp_unit_tb_top

`default_nettype wire
